// ### design/sfd_pkg.sv
// shared constants for the switch forwarding decision block
package sfd_pkg;

  // port layout: ports 0..9 are front ports, port 10 is the cpu port
  localparam int NUM_PORTS = 11;
  localparam int PORT_W = 4;
  localparam logic [PORT_W-1:0] CPU_PORT = 4'hA;
  localparam int NUM_QUEUES = 8;
  localparam int QUEUE_W = 3;
  localparam int GROUP_ENTRIES = 64;
  localparam int GROUP_IDX_W = 6;
  localparam int VID_W = 12;
  localparam int VLAN_ENTRIES = 4096;

  // vlan table entry layout
  localparam int VL_MIRROR_BIT = 11;
  localparam int VL_SRCCHK_BIT = 12;
  localparam int VL_NOLEARN_BIT = 13;
  localparam int VL_PRIV_BIT = 14;
  localparam int VL_W = 15;
  localparam logic [VL_W-1:0] VL_DEFAULT = 15'h07FF;

  // flood type classification codes (dmac and ip fields)
  localparam logic [23:0] IP4_MC_OUI = 24'h01005E;
  localparam logic [15:0] IP6_MC_PREFIX = 16'h3333;
  localparam logic [23:0] IP4_LOCAL_NET = 24'hE00000;
  localparam logic [15:0] IP6_LOCAL_SCOPE = 16'hFF02;
  localparam int DMAC_GROUP_BIT = 40;

  // register byte offsets
  localparam logic [11:0] OFS_FLOOD0 = 12'h000;
  localparam logic [11:0] OFS_FLOOD1 = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_FILTER_MASK = 12'h00C;
  localparam logic [11:0] OFS_RX_ALLOW = 12'h010;
  localparam logic [11:0] OFS_ISOLATED = 12'h014;
  localparam logic [11:0] OFS_COMMUNITY = 12'h018;
  localparam logic [11:0] OFS_VLAN_IDX = 12'h01C;
  localparam logic [11:0] OFS_VLAN_DATA = 12'h020;
  localparam logic [11:0] OFS_VLAN_CMD = 12'h024;
  localparam logic [11:0] OFS_STATUS = 12'h028;
  localparam logic [11:0] OFS_GROUP_BASE = 12'h100;
  localparam logic [11:0] OFS_SRCMASK_BASE = 12'h200;

  // field positions
  localparam int FLD0_UC_LSB = 0;
  localparam int FLD0_BC_LSB = 8;
  localparam int FLD0_MC_LSB = 16;
  localparam int FLD1_IP4C_LSB = 0;
  localparam int FLD1_IP4D_LSB = 8;
  localparam int FLD1_IP6C_LSB = 16;
  localparam int FLD1_IP6D_LSB = 24;
  localparam int CTRL_SKIP_BIT = 0;
  localparam int CTRL_FLOODBYP_BIT = 1;
  localparam int CTRL_FILTLRN_BIT = 2;
  localparam int CTRL_HOSTQ_LSB = 4;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int STAT_LEARN_BIT = 16;

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [NUM_PORTS-1:0] RST_ALL_PORTS = 11'h7FF;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // init sweep states
  typedef enum logic [1:0] {
    INIT_RUN = 2'b01,
    INIT_DONE = 2'b10
  } sfd_init_t;

endpackage

// ### design/sfd_forward.sv
// forwarding decision: dmac analysis and vlan analysis with axi4-lite config
module sfd_forward
  import sfd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // frame request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [47:0] req_dmac,
  input wire logic [VID_W-1:0] req_vid,
  input wire logic [PORT_W-1:0] physical_ingress_port,
  input wire logic req_etype_ip4,
  input wire logic req_etype_ip6,
  input wire logic req_proto_igmp,
  input wire logic [31:0] req_dip4,
  input wire logic [15:0] req_dip6_top,
  // mac table lookup result
  input wire logic mac_hit,
  input wire logic [1:0] entry_type,
  input wire logic [GROUP_IDX_W-1:0] entry_group_index,
  input wire logic [QUEUE_W-1:0] entry_cpu_queue,
  input wire logic entry_copy_to_host,
  input wire logic entry_bypass_membership,
  // basic classifier cpu forwarding
  input wire logic cls_copy,
  input wire logic cls_redirect,
  input wire logic [QUEUE_W-1:0] cls_queue,
  // source address lookup result
  input wire logic copy_to_host_enable,
  input wire logic [QUEUE_W-1:0] host_queue_number,
  input wire logic discard_enable,
  // forwarding result
  output logic res_valid,
  output logic [NUM_PORTS-1:0] forward_port_set,
  output logic [NUM_QUEUES-1:0] cpu_extract_queue_mask,
  output logic learn_off_flag
);

  // merge a write under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // one-hot bit for a queue number
  function automatic logic [NUM_QUEUES-1:0] qbit(input logic [QUEUE_W-1:0] q);
    qbit = {{(NUM_QUEUES-1){1'b0}}, 1'b1} << q;
  endfunction

  // configuration state
  logic [31:0] flood0_reg;
  logic [31:0] flood1_reg;
  logic [31:0] ctrl_reg;
  logic [NUM_PORTS-1:0] filter_mask_reg;
  logic [NUM_PORTS-1:0] rx_allow_reg;
  logic [NUM_PORTS-1:0] isolated_reg;
  logic [NUM_PORTS-1:0] community_reg;
  logic [VID_W-1:0] vlan_idx_reg;
  logic [VL_W-1:0] vlan_data_reg;
  logic [NUM_PORTS-1:0] group_mask_table [GROUP_ENTRIES];
  logic [NUM_PORTS-1:0] src_mask_reg [NUM_PORTS];
  logic [VL_W-1:0] vlan_tab [VLAN_ENTRIES];

  // bus handshake state
  logic wr_go;
  logic [11:0] rd_addr;
  logic vlan_wr_go;
  logic vlan_rd_pend_reg;
  logic [VL_W-1:0] vlan_cfg_q;

  // init sweep state
  sfd_init_t init_state_reg;
  logic [VID_W-1:0] init_cnt_reg;

  // pipeline state
  logic s1_valid_reg;
  logic [NUM_PORTS-1:0] s1_set_reg;
  logic [NUM_QUEUES-1:0] s1_cpu_extract_queue_mask_reg;
  logic s1_bypass_reg;
  logic [PORT_W-1:0] s1_port_reg;
  logic [VL_W-1:0] s1_vlan_q;
  logic skip_flags;

  assign skip_flags = ctrl_reg[CTRL_SKIP_BIT];

  // write taken when address and data are both offered and no response pends
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr = s_axi_araddr;
  assign vlan_wr_go = wr_go && (s_axi_awaddr == OFS_VLAN_CMD) && s_axi_wstrb[0] &&
                      s_axi_wdata[CMD_WRITE_BIT];

  // decode helpers
  function automatic logic is_group(input logic [11:0] a);
    // compare at 7 bits: the entry count does not fit the 6-bit index field
    return (a[11:8] == OFS_GROUP_BASE[11:8]) && (7'(a[7:2]) < 7'(GROUP_ENTRIES)) &&
           (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_src(input logic [11:0] a);
    return (a[11:8] == OFS_SRCMASK_BASE[11:8]) && (a[7:2] < 6'(NUM_PORTS)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_plain(input logic [11:0] a);
    return (a[11:6] == 6'h00) && (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction

  // write response channel
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (is_plain(s_axi_awaddr) || is_group(s_axi_awaddr) || is_src(s_axi_awaddr)) ?
                     RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // plain control registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flood0_reg <= RST_ZERO;
      flood1_reg <= RST_ZERO;
      ctrl_reg <= RST_ZERO;
      filter_mask_reg <= '0;
      rx_allow_reg <= RST_ALL_PORTS;
      isolated_reg <= RST_ALL_PORTS;
      community_reg <= RST_ALL_PORTS;
      vlan_idx_reg <= '0;
    end else if (wr_go) begin
      case (s_axi_awaddr)
        OFS_FLOOD0: flood0_reg <= strb_merge(flood0_reg, s_axi_wdata, s_axi_wstrb) & 32'h003F3F3F;
        OFS_FLOOD1: flood1_reg <= strb_merge(flood1_reg, s_axi_wdata, s_axi_wstrb) & 32'h3F3F3F3F;
        OFS_CTRL: ctrl_reg <= strb_merge(ctrl_reg, s_axi_wdata, s_axi_wstrb) & 32'h00000077;
        OFS_FILTER_MASK: filter_mask_reg <=
          NUM_PORTS'(strb_merge({21'h0, filter_mask_reg}, s_axi_wdata, s_axi_wstrb));
        OFS_RX_ALLOW: rx_allow_reg <=
          NUM_PORTS'(strb_merge({21'h0, rx_allow_reg}, s_axi_wdata, s_axi_wstrb));
        OFS_ISOLATED: isolated_reg <=
          NUM_PORTS'(strb_merge({21'h0, isolated_reg}, s_axi_wdata, s_axi_wstrb));
        OFS_COMMUNITY: community_reg <=
          NUM_PORTS'(strb_merge({21'h0, community_reg}, s_axi_wdata, s_axi_wstrb));
        OFS_VLAN_IDX: vlan_idx_reg <=
          VID_W'(strb_merge({20'h0, vlan_idx_reg}, s_axi_wdata, s_axi_wstrb));
        default: ;
      endcase
    end
  end

  // vlan staging data: software write, or table contents after a read command
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vlan_data_reg <= VL_DEFAULT;
      vlan_rd_pend_reg <= 1'b0;
    end else begin
      vlan_rd_pend_reg <= wr_go && (s_axi_awaddr == OFS_VLAN_CMD) && s_axi_wstrb[0] &&
                          s_axi_wdata[CMD_READ_BIT];
      if (vlan_rd_pend_reg) begin
        vlan_data_reg <= vlan_cfg_q;
      end else if (wr_go && s_axi_awaddr == OFS_VLAN_DATA) begin
        vlan_data_reg <= VL_W'(strb_merge({17'h0, vlan_data_reg}, s_axi_wdata, s_axi_wstrb));
      end
    end
  end

  // group masks 0..63 and per-port source masks
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < GROUP_ENTRIES; i++) begin
        group_mask_table[i] <= '0;
      end
      // source default all ports but self
      for (int p = 0; p < NUM_PORTS; p++) begin
        src_mask_reg[p] <= RST_ALL_PORTS & ~(11'h001 << p);
      end
    end else if (wr_go && is_group(s_axi_awaddr)) begin
      group_mask_table[s_axi_awaddr[7:2]] <=
        NUM_PORTS'(strb_merge({21'h0, group_mask_table[s_axi_awaddr[7:2]]}, s_axi_wdata,
                              s_axi_wstrb));
    end else if (wr_go && is_src(s_axi_awaddr)) begin
      src_mask_reg[s_axi_awaddr[5:2]] <=
        NUM_PORTS'(strb_merge({21'h0, src_mask_reg[s_axi_awaddr[5:2]]}, s_axi_wdata,
                              s_axi_wstrb));
    end
  end

  // init sweep makes every port a member of every vlan after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      init_state_reg <= INIT_RUN;
      init_cnt_reg <= '0;
    end else begin
      case (init_state_reg)
        INIT_RUN: begin
          init_cnt_reg <= init_cnt_reg + 12'h001;
          if (init_cnt_reg == 12'hFFF) begin
            init_state_reg <= INIT_DONE;
          end
        end
        INIT_DONE: init_state_reg <= INIT_DONE;
        default: init_state_reg <= INIT_RUN;
      endcase
    end
  end

  // vlan table storage, no reset: the sweep fills it
  always_ff @(posedge sys_clk) begin
    if (init_state_reg == INIT_RUN) begin
      vlan_tab[init_cnt_reg] <= VL_DEFAULT;
    end else if (vlan_wr_go) begin
      vlan_tab[vlan_idx_reg] <= vlan_data_reg;
    end
    vlan_cfg_q <= vlan_tab[vlan_idx_reg];
    s1_vlan_q <= vlan_tab[req_vid];
  end

  // read data channel
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (is_group(rd_addr)) begin
        s_axi_rdata <= {21'h0, group_mask_table[rd_addr[7:2]]};
      end else if (is_src(rd_addr)) begin
        s_axi_rdata <= {21'h0, src_mask_reg[rd_addr[5:2]]};
      end else begin
        case (rd_addr)
          OFS_FLOOD0: s_axi_rdata <= flood0_reg;
          OFS_FLOOD1: s_axi_rdata <= flood1_reg;
          OFS_CTRL: s_axi_rdata <= ctrl_reg;
          OFS_FILTER_MASK: s_axi_rdata <= {21'h0, filter_mask_reg};
          OFS_RX_ALLOW: s_axi_rdata <= {21'h0, rx_allow_reg};
          OFS_ISOLATED: s_axi_rdata <= {21'h0, isolated_reg};
          OFS_COMMUNITY: s_axi_rdata <= {21'h0, community_reg};
          OFS_VLAN_IDX: s_axi_rdata <= {20'h0, vlan_idx_reg};
          OFS_VLAN_DATA: s_axi_rdata <= {17'h0, vlan_data_reg};
          OFS_VLAN_CMD: s_axi_rdata <= {31'h0, init_state_reg == INIT_RUN};
          OFS_STATUS: s_axi_rdata <= {15'h0, learn_off_flag, 5'h0, forward_port_set};
          default: begin
            s_axi_rdata <= RST_ZERO;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // requests wait while the vlan table is being filled
  assign req_ready = (init_state_reg == INIT_DONE);

  // dmac analysis step, combinational on the request
  logic [NUM_PORTS-1:0] d_set;
  logic [NUM_QUEUES-1:0] d_cpu_extract_queue_mask;
  logic d_bypass;
  logic [GROUP_IDX_W-1:0] d_flood_idx;
  logic ip4_mc;
  logic ip6_mc;
  always_comb begin
    ip4_mc = (req_dmac[47:24] == IP4_MC_OUI) && !req_dmac[23] && req_etype_ip4 && !req_proto_igmp;
    ip6_mc = (req_dmac[47:32] == IP6_MC_PREFIX) && req_etype_ip6;
    if (ip4_mc && req_dip4[31:8] != IP4_LOCAL_NET) begin
      d_flood_idx = flood1_reg[FLD1_IP4D_LSB +: GROUP_IDX_W];
    end else if (ip4_mc) begin
      d_flood_idx = flood1_reg[FLD1_IP4C_LSB +: GROUP_IDX_W];
    end else if (ip6_mc && req_dip6_top != IP6_LOCAL_SCOPE) begin
      d_flood_idx = flood1_reg[FLD1_IP6D_LSB +: GROUP_IDX_W];
    end else if (ip6_mc) begin
      d_flood_idx = flood1_reg[FLD1_IP6C_LSB +: GROUP_IDX_W];
    end else if (&req_dmac) begin
      d_flood_idx = flood0_reg[FLD0_BC_LSB +: GROUP_IDX_W];
    end else if (req_dmac[DMAC_GROUP_BIT]) begin
      d_flood_idx = flood0_reg[FLD0_MC_LSB +: GROUP_IDX_W];
    end else begin
      d_flood_idx = flood0_reg[FLD0_UC_LSB +: GROUP_IDX_W];
    end
    d_cpu_extract_queue_mask = '0;
    // entry mask on a hit, flood mask on a miss
    d_set = mac_hit ? group_mask_table[entry_group_index] : group_mask_table[d_flood_idx];
    // cpu member of entry group adds entry queue for entry types 0 and 1
    if (mac_hit && entry_type <= 2'h1 && d_set[CPU_PORT]) begin
      d_cpu_extract_queue_mask = d_cpu_extract_queue_mask | qbit(entry_cpu_queue);
    end
    if (mac_hit && entry_copy_to_host && !skip_flags) begin
      d_cpu_extract_queue_mask = d_cpu_extract_queue_mask | qbit(ctrl_reg[CTRL_HOSTQ_LSB +: QUEUE_W]);
    end
    if (cls_copy || cls_redirect) begin
      d_cpu_extract_queue_mask = d_cpu_extract_queue_mask | qbit(cls_queue);
    end
    if (cls_redirect) begin
      d_set = '0;
    end
    if (copy_to_host_enable) begin
      d_cpu_extract_queue_mask = d_cpu_extract_queue_mask | qbit(host_queue_number);
    end
    if (discard_enable) begin
      d_set = '0;
    end
    // cpu reached only through the queue mask
    d_set[CPU_PORT] = 1'b0;
    d_bypass = !skip_flags && ((mac_hit && entry_bypass_membership) ||
                               (!mac_hit && ctrl_reg[CTRL_FLOODBYP_BIT]));
  end

  // dmac result registered before the vlan step reads it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_valid_reg <= 1'b0;
      s1_set_reg <= '0;
      s1_cpu_extract_queue_mask_reg <= '0;
      s1_bypass_reg <= 1'b0;
      s1_port_reg <= '0;
    end else begin
      s1_valid_reg <= req_valid && req_ready;
      if (req_valid && req_ready) begin
        s1_set_reg <= d_set;
        s1_cpu_extract_queue_mask_reg <= d_cpu_extract_queue_mask;
        s1_bypass_reg <= d_bypass;
        s1_port_reg <= physical_ingress_port;
      end
    end
  end

  // vlan analysis step
  logic [NUM_PORTS-1:0] v_set;
  logic [NUM_PORTS-1:0] v_member;
  logic v_filter_drop;
  logic v_learn_off;
  always_comb begin
    v_member = s1_vlan_q[NUM_PORTS-1:0];
    v_member[CPU_PORT] = 1'b1;
    v_set = s1_set_reg;
    if (!s1_bypass_reg) begin
      v_set = v_set & v_member;
    end
    if (s1_vlan_q[VL_PRIV_BIT]) begin
      if (!isolated_reg[s1_port_reg]) begin
        v_set = v_set & isolated_reg & community_reg;
      end else if (!community_reg[s1_port_reg]) begin
        v_set = v_set & isolated_reg;
      end
    end
    v_filter_drop = (filter_mask_reg[s1_port_reg] || s1_vlan_q[VL_SRCCHK_BIT]) &&
                    !v_member[s1_port_reg];
    if (v_filter_drop) begin
      v_set = '0;
    end
    if (!rx_allow_reg[s1_port_reg]) begin
      v_set = '0;
    end
    v_set = v_set & src_mask_reg[s1_port_reg];
    v_learn_off = s1_vlan_q[VL_NOLEARN_BIT] || (v_filter_drop && ctrl_reg[CTRL_FILTLRN_BIT]);
  end

  // result registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      res_valid <= 1'b0;
      forward_port_set <= '0;
      cpu_extract_queue_mask <= '0;
      learn_off_flag <= 1'b0;
    end else begin
      res_valid <= s1_valid_reg;
      if (s1_valid_reg) begin
        forward_port_set <= v_set;
        cpu_extract_queue_mask <= s1_cpu_extract_queue_mask_reg;
        // flag handed to the learning step
        learn_off_flag <= v_learn_off;
      end
    end
  end

endmodule // sfd_forward

// ### tb/sfd_port_model.sv
// port module model raising frame requests toward the analyzer
module sfd_port_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // bench trigger and analyzer handshake
  input wire logic go,
  input wire logic req_ready,
  output logic req_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // hold the request until taken, never withdrawn early
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_valid <= 1'b0;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
    end else if (go) begin
      req_valid <= 1'b1;
    end
  end
endmodule // sfd_port_model

// ### tb/sfd_forward_checker.sv
// concurrent checks on the forwarding decision ports
module sfd_forward_checker
  import sfd_pkg::*;
(
  // clock, reset and request handshake
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_ready,
  // cpu forwarding inputs
  input wire logic cls_copy,
  input wire logic cls_redirect,
  input wire logic [QUEUE_W-1:0] cls_queue,
  input wire logic copy_to_host_enable,
  input wire logic [QUEUE_W-1:0] host_queue_number,
  input wire logic discard_enable,
  // result
  input wire logic res_valid,
  input wire logic [NUM_PORTS-1:0] forward_port_set,
  input wire logic [NUM_QUEUES-1:0] cpu_extract_queue_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // request taken this edge
  logic fire;
  assign fire = req_valid && req_ready;
  a_cpu_clear: assert property (res_valid |-> !forward_port_set[CPU_PORT])
    else $error("cpu port in forward set");
  a_result_lat: assert property (fire |-> ##2 res_valid)
    else $error("result missing two cycles after request");
  a_no_spurious: assert property (res_valid |-> $past(fire, 2))
    else $error("result without request");
  a_result_hold: assert property (!res_valid |-> $stable(forward_port_set))
    else $error("forward set moved between results");
  a_redir_clear: assert property (fire && cls_redirect |-> ##2 forward_port_set == '0)
    else $error("redirect left ports set");
  a_cls_queue: assert property (fire && (cls_copy || cls_redirect)
    |-> ##2 cpu_extract_queue_mask[$past(cls_queue, 2)]) else $error("classifier queue missing");
  a_src_queue: assert property (fire && copy_to_host_enable
    |-> ##2 cpu_extract_queue_mask[$past(host_queue_number, 2)]) else $error("source queue missing");
  a_kill_clear: assert property (fire && discard_enable |-> ##2 forward_port_set == '0)
    else $error("discard left ports set");
endmodule // sfd_forward_checker

bind sfd_forward sfd_forward_checker chk (.*);

// ### tb/sfd_forward_tb.sv
// self-checking bench for the forwarding decision block
module sfd_forward_tb
  import sfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // bus, request and result signals, named as the ports
  logic sys_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, go;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, req_dip4, rd_word;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, entry_type, rd_resp;
  logic req_valid, req_ready, req_etype_ip4, req_etype_ip6, req_proto_igmp, mac_hit;
  logic entry_copy_to_host, entry_bypass_membership, cls_copy, cls_redirect;
  logic copy_to_host_enable, discard_enable, res_valid, learn_off_flag;
  logic [47:0] req_dmac;
  logic [VID_W-1:0] req_vid;
  logic [PORT_W-1:0] physical_ingress_port;
  logic [15:0] req_dip6_top;
  logic [GROUP_IDX_W-1:0] entry_group_index;
  logic [QUEUE_W-1:0] entry_cpu_queue, cls_queue, host_queue_number;
  logic [NUM_PORTS-1:0] forward_port_set;
  logic [NUM_QUEUES-1:0] cpu_extract_queue_mask;
  int mismatches, tests_run;

  sfd_forward dut (.*);
  sfd_port_model partner (.*);

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // sample at the falling edge so the value is settled, act after the rising one
  task wh(input int s);
    logic t;
    do begin
      @(negedge sys_clk);
      t = s == 0 ? s_axi_awready : s == 1 ? s_axi_bvalid : s == 2 ? s_axi_arready :
          s == 3 ? s_axi_rvalid : s == 4 ? res_valid : req_ready;
      rd_word = s_axi_rdata;
      rd_resp = s == 1 ? s_axi_bresp : s_axi_rresp;
      @(posedge sys_clk);
    end while (t !== 1'b1);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wh(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wh(1);
    chk("bresp", er, rd_resp);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wh(2);
    s_axi_arvalid <= 1'b0;
    wh(3);
    chk("rdata", e, rd_word);
    chk("rresp", er, rd_resp);
  endtask

  // plain unicast miss on vid 1 from port 0; takes one edge
  task idle();
    req_dmac <= 48'h0000_0000_0002;
    req_vid <= 12'h001;
    physical_ingress_port <= 4'h0;
    {req_dip4, req_dip6_top, entry_group_index} <= '0;
    {entry_cpu_queue, cls_queue, host_queue_number, entry_type} <= '0;
    {req_etype_ip4, req_etype_ip6, req_proto_igmp, mac_hit, entry_copy_to_host,
     entry_bypass_membership, cls_copy, cls_redirect, copy_to_host_enable, discard_enable} <= '0;
    @(posedge sys_clk);
  endtask

  task fr(input logic [31:0] es, input logic [31:0] eq, input logic el);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    wh(4);
    chk("forward set", es, forward_port_set);
    chk("queue mask", eq, cpu_extract_queue_mask);
    chk("learn off", {31'h0, el}, {31'h0, learn_off_flag});
  endtask

  task t_regs();
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_RX_ALLOW, 32'h7FF, RESP_OKAY);
    rd(OFS_SRCMASK_BASE + 12'h00C, 32'h7F7, RESP_OKAY);
    wr(12'h300, 32'h1, RESP_SLVERR);
    rd(12'h300, 32'h0, RESP_SLVERR);
    $display("register test done");
  endtask

  // miss of each flood class; group i holds cpu, port 8 and port i
  task fl(input logic [47:0] d, input logic [2:0] f, input logic [31:0] a4,
          input logic [15:0] a6, input int i);
    idle();
    req_dmac <= d;
    {req_etype_ip4, req_etype_ip6, req_proto_igmp} <= f;
    req_dip4 <= a4;
    req_dip6_top <= a6;
    fr(32'h100 | (32'h1 << i), 32'h0, 1'b0);
  endtask

  task t_flood();
    for (int i = 1; i < 8; i++) begin
      wr(OFS_GROUP_BASE + 12'(4 * i), 32'h500 | (32'h1 << i), RESP_OKAY);
    end
    wr(OFS_FLOOD0, 32'h0003_0201, RESP_OKAY);
    wr(OFS_FLOOD1, 32'h0706_0504, RESP_OKAY);
    fl(48'h0000_0000_0002, 3'b000, 32'h0, 16'h0, 1);
    fl(48'hFFFF_FFFF_FFFF, 3'b000, 32'h0, 16'h0, 2);
    fl(48'h0100_0000_0001, 3'b000, 32'h0, 16'h0, 3);
    fl(48'h0100_5E00_0001, 3'b100, 32'hE000_0005, 16'h0, 4);
    fl(48'h0100_5E00_0001, 3'b100, 32'hE100_0001, 16'h0, 5);
    fl(48'h3333_0000_0001, 3'b010, 32'h0, 16'hFF02, 6);
    fl(48'h3333_0000_0001, 3'b010, 32'h0, 16'hFF05, 7);
    fl(48'h0100_5E00_0001, 3'b101, 32'hE100_0001, 16'h0, 3);
    $display("flood test done");
  endtask

  task t_hit();
    wr(OFS_GROUP_BASE + 12'h024, 32'h40C, RESP_OKAY);
    wr(OFS_CTRL, 32'h20, RESP_OKAY);
    idle();
    mac_hit <= 1'b1;
    entry_group_index <= 6'h09;
    entry_cpu_queue <= 3'h5;
    entry_copy_to_host <= 1'b1;
    fr(32'h00C, 32'h24, 1'b0);
    wr(OFS_CTRL, 32'h21, RESP_OKAY);
    entry_type <= 2'h2;
    fr(32'h00C, 32'h0, 1'b0);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    $display("lookup hit test done");
  endtask

  task t_cpu();
    idle();
    {cls_copy, copy_to_host_enable, cls_queue, host_queue_number} <= {2'b11, 3'h1, 3'h6};
    fr(32'h102, 32'h42, 1'b0);
    idle();
    {cls_redirect, cls_queue} <= {1'b1, 3'h3};
    fr(32'h0, 32'h08, 1'b0);
    idle();
    {discard_enable, cls_copy, cls_queue} <= {2'b11, 3'h7};
    fr(32'h0, 32'h80, 1'b0);
    $display("cpu forwarding test done");
  endtask

  task vl(input logic [11:0] v, input logic [31:0] d);
    wr(OFS_VLAN_IDX, {20'h0, v}, RESP_OKAY);
    wr(OFS_VLAN_DATA, d, RESP_OKAY);
    wr(OFS_VLAN_CMD, 32'h1, RESP_OKAY);
  endtask

  task t_vlan();
    wr(OFS_GROUP_BASE + 12'h028, 32'h0FF, RESP_OKAY);
    vl(12'h005, 32'h200F);
    vl(12'h006, 32'h100F);
    vl(12'h007, 32'h47FF);
    idle();
    {mac_hit, entry_group_index, req_vid} <= {1'b1, 6'h0A, 12'h005};
    fr(32'h00E, 32'h0, 1'b1);
    entry_bypass_membership <= 1'b1;
    fr(32'h0FE, 32'h0, 1'b1);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    fr(32'h00E, 32'h0, 1'b1);
    wr(OFS_CTRL, 32'h4, RESP_OKAY);
    {req_vid, physical_ingress_port} <= {12'h006, 4'h9};
    fr(32'h0, 32'h0, 1'b1);
    rd(OFS_STATUS, 32'h0001_0000, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wr(OFS_ISOLATED, 32'h7FB, RESP_OKAY);
    wr(OFS_COMMUNITY, 32'h7F5, RESP_OKAY);
    {req_vid, physical_ingress_port} <= {12'h007, 4'h1};
    fr(32'h0F9, 32'h0, 1'b0);
    physical_ingress_port <= 4'h2;
    fr(32'h0F1, 32'h0, 1'b0);
    wr(OFS_SRCMASK_BASE + 12'h010, 32'h7CF, RESP_OKAY);
    physical_ingress_port <= 4'h4;
    fr(32'h0CF, 32'h0, 1'b0);
    rd(OFS_STATUS, 32'h0CF, RESP_OKAY);
    wr(OFS_RX_ALLOW, 32'h7EF, RESP_OKAY);
    fr(32'h0, 32'h0, 1'b0);
    // read command pulls entry 5 back into the staging word
    wr(OFS_VLAN_IDX, 32'h5, RESP_OKAY);
    wr(OFS_VLAN_CMD, 32'h2, RESP_OKAY);
    rd(OFS_VLAN_DATA, 32'h200F, RESP_OKAY);
    rd(OFS_VLAN_CMD, 32'h0, RESP_OKAY);
    $display("vlan test done");
  endtask

  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence: reset, wait out the vlan sweep, run the scenarios
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    resetn = 1'b0;
    mismatches = 0;
    tests_run = 0;
    idle();
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    wh(5);
    t_regs();
    t_flood();
    t_hit();
    t_cpu();
    t_vlan();
    give_verdict();
  end

  // watchdog: sweep plus scenarios need well under 20000 cycles
  initial begin
    #100us;
    mismatches++;
    give_verdict();
  end
endmodule // sfd_forward_tb
